// File: common/satellite_cascade_defs.vh
// Purpose: Shared constants of the satellite cascade and handshake block
// Assumes: 125 MHz clock, classic Wishbone register access
// Notes: Definitions only
`ifndef SATELLITE_CASCADE_DEFS_VH
`define SATELLITE_CASCADE_DEFS_VH

// Clock and strobe timing
`define CLK_MHZ 125
`define STROBE_NS 40
`define STROBE_CYC ((`STROBE_NS * `CLK_MHZ + 999) / 1000)

// Widths and FIFO depth
`define ADDR_W 6
`define WORD_W 16
`define CODE_W 4
`define FIFO_DEPTH 8

// Command codes
`define CMD_BASIC_A 4'h0
`define CMD_BASIC_B 4'h8
`define CMD_IDENT_A 4'h7
`define CMD_IDENT_B 4'hF

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_SAMPLE 8'h08
`define REG_STROBES 8'h0C
`define REG_IDENT 8'h10

// Control fields and reset value
`define CTRL_RESP_EN 0
`define CTRL_HS_OFF 1
`define CTRL_RESET 32'h0000_0001

// Status fields
`define ST_HS_ACTIVE 0
`define ST_FIFO_FULL 1
`define ST_FIFO_EMPTY 2
`define ST_HELD 3
`define ST_TX_BUSY 4

// Ident word reset value, arbitrary
`define IDENT_RESET 16'h0000

`endif

// File: src/response_fifo.v
// Purpose: Response word buffer with valid and ready on both sides
// Assumes: Single clock, synchronous active high reset
// Notes: Honest full and empty, no write while full
module response_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o,
  output wire full_o,
  output wire empty_o
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  assign full_o = (count == DEPTH);
  assign empty_o = (count == 0);
  assign in_ready_o = !full_o;
  assign out_valid_o = !empty_o;
  assign out_data_o = mem[rd_ptr];
  assign push = ce_i && in_valid_i && !full_o;
  assign pop = ce_i && out_ready_i && !empty_o;

  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // response_fifo

// File: src/response_shifter.v
// Purpose: Shifts response words out serially, MSB first
// Assumes: Words arrive from the response buffer
// Notes: Enable stays high for the whole word
module response_shifter #(
  parameter WIDTH = 16
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire word_valid_i,
  output wire word_ready_o,
  input wire [WIDTH-1:0] word_i,
  output reg tx_en_o,
  output reg tx_bit_o
);

  reg [WIDTH-1:0] shift;
  reg [4:0] left;

  assign word_ready_o = (left == 5'd0);

  always @(posedge clk_i) begin
    if (rst_i) begin
      shift <= {WIDTH{1'b0}};
      left <= 5'd0;
      tx_en_o <= 1'b0;
      tx_bit_o <= 1'b0;
    end else if (ce_i) begin
      if (left == 5'd0) begin
        tx_en_o <= 1'b0;
        tx_bit_o <= 1'b0;
        if (word_valid_i) begin
          shift <= word_i;
          left <= WIDTH[4:0];
        end
      end else begin
        tx_en_o <= 1'b1;
        tx_bit_o <= shift[WIDTH-1];
        shift <= {shift[WIDTH-2:0], 1'b0};
        left <= left - 5'd1;
      end
    end
  end

endmodule // response_shifter

// File: src/satellite_cascade_handshake.v
// Purpose: Satellite node chaining and handshake-gated input sampling
// Assumes: Commands arrive already decoded and addressed to this node
// Notes: Counter function lives outside; requests are routed to it
//
// Overview of operation
// - Handshake on: strobe only for codes 0, 8
// - Next-address outputs carry station address plus one
// - Clock-chain output forwards clock, even in reset
// - Receive stream passed unchanged to chain output
// - OR enables; OR enable-gated data streams
// - Address chaining only with address-output mode high
// - Lost response: keep sample, send next scan
// - Corrupted command: no sample is lost
// - Counter read and clear codes go to counter
// - Handshake select low enables handshake
// - Handshake on: strobe only after acknowledged response
// - Blocked sample: resend previous value, no strobe
// - Sample all inputs at strobe start
//
// The implementer's own choices: the Wishbone slave port and the register offsets.
`include "satellite_cascade_defs.vh"

module satellite_cascade_handshake (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Station addressing
  input wire [5:0] station_address_in_i,
  input wire address_output_mode_i,
  output reg [5:0] next_station_address_out_o,
  // Chain pins
  output wire clock_chain_out_o,
  input wire serial_receive_in_i,
  output reg receive_chain_out_o,
  input wire chained_tx_enable_in_i,
  input wire chained_tx_data_in_i,
  output reg transmit_enable_out_o,
  output reg transmit_data_out_o,
  // Decoded command packet
  input wire cmd_valid_i,
  input wire [3:0] cmd_code_i,
  input wire cmd_rp_ok_i,
  output reg cmd_ready_o,
  // Handshake and sampling
  input wire handshake_select_n_i,
  input wire [15:0] parallel_input_pins_i,
  output reg input_sample_strobe_o,
  // Counter function
  output reg counter_req_o,
  output reg [3:0] counter_code_o,
  input wire [15:0] counter_value_i
);

  ////////////////////////////////////////////////////////////////////
  // Declarations

  reg [31:0] ctrl;
  reg [15:0] ident;
  reg [15:0] held_sample;
  reg [15:0] strobe_count;
  reg held_valid;
  reg [3:0] strobe_left;
  reg wait_counter;
  reg [15:0] resp_word;
  reg resp_valid;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [15:0] fifo_out_data;
  wire fifo_full;
  wire fifo_empty;
  wire shifter_ready;
  wire own_tx_en;
  wire own_tx_bit;
  wire hs_active;
  wire basic_cmd;
  wire ident_cmd;
  wire take_cmd;
  wire take_sample;
  wire wb_req;
  wire [3:0] strobe_len;

  // Strobe length cut to the counter's width on purpose
  localparam integer STROBE_CYCLES = `STROBE_CYC;
  assign strobe_len = STROBE_CYCLES[3:0];

  ////////////////////////////////////////////////////////////////////
  // Command classification

  assign hs_active = !handshake_select_n_i && !ctrl[`CTRL_HS_OFF];
  assign basic_cmd = (cmd_code_i == `CMD_BASIC_A) ||
                     (cmd_code_i == `CMD_BASIC_B);
  assign ident_cmd = (cmd_code_i == `CMD_IDENT_A) ||
                     (cmd_code_i == `CMD_IDENT_B);
  assign take_cmd = ce_i && cmd_valid_i && cmd_ready_o && !wait_counter;
  // Fresh sample when handshake is off or the last answer was acknowledged
  assign take_sample = take_cmd && basic_cmd &&
                       (!hs_active || cmd_rp_ok_i);

  ////////////////////////////////////////////////////////////////////
  // Clock forwarding

  // Passes the driving clock through untouched; never gated by reset
  assign clock_chain_out_o = clk_i;

  ////////////////////////////////////////////////////////////////////
  // Address chaining, kept out of reset so it settles early

  always @(posedge clk_i) begin
    if (ce_i) begin
      if (address_output_mode_i) begin
        next_station_address_out_o <= station_address_in_i + 6'h01;
      end else begin
        next_station_address_out_o <= 6'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Receive pass-through and transmit merging

  always @(posedge clk_i) begin
    if (rst_i) begin
      receive_chain_out_o <= 1'b0;
      transmit_enable_out_o <= 1'b0;
      transmit_data_out_o <= 1'b0;
    end else if (ce_i) begin
      receive_chain_out_o <= serial_receive_in_i;
      transmit_enable_out_o <= own_tx_en | chained_tx_enable_in_i;
      // Idle last node relies on chained enable held low; chained data is gated by it
      transmit_data_out_o <= (own_tx_en & own_tx_bit) |
        (chained_tx_enable_in_i & chained_tx_data_in_i);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sampling, strobe and held value

  always @(posedge clk_i) begin
    if (rst_i) begin
      held_sample <= 16'h0000;
      held_valid <= 1'b0;
      strobe_left <= 4'h0;
      input_sample_strobe_o <= 1'b0;
      strobe_count <= 16'h0000;
    end else if (ce_i) begin
      if (take_sample) begin
        // Pins are captured on the strobe's first cycle
        held_sample <= parallel_input_pins_i;
        held_valid <= 1'b1;
        strobe_left <= strobe_len;
        input_sample_strobe_o <= 1'b1;
        strobe_count <= strobe_count + 16'h0001;
      end else if (strobe_left > 4'h1) begin
        strobe_left <= strobe_left - 4'h1;
      end else begin
        strobe_left <= 4'h0;
        input_sample_strobe_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Response word assembly

  // Counter codes wait one cycle for the external counter value
  always @(posedge clk_i) begin
    if (rst_i) begin
      resp_word <= 16'h0000;
      resp_valid <= 1'b0;
      wait_counter <= 1'b0;
      counter_req_o <= 1'b0;
      counter_code_o <= 4'h0;
    end else if (ce_i) begin
      counter_req_o <= 1'b0;
      if (resp_valid && fifo_in_ready) begin
        resp_valid <= 1'b0;
      end
      if (wait_counter) begin
        wait_counter <= 1'b0;
        resp_word <= counter_value_i;
        resp_valid <= ctrl[`CTRL_RESP_EN];
      end else if (take_cmd) begin
        if (basic_cmd) begin
          // Blocked sample resends the held value without a strobe
          resp_word <= take_sample ? parallel_input_pins_i
                                   : held_sample;
          resp_valid <= ctrl[`CTRL_RESP_EN];
        end else if (ident_cmd) begin
          resp_word <= ident;
          resp_valid <= ctrl[`CTRL_RESP_EN];
        end else begin
          counter_req_o <= 1'b1;
          counter_code_o <= cmd_code_i;
          wait_counter <= 1'b1;
        end
      end
    end
  end

  // Back-pressure: refuse commands while a word is still pending
  always @(posedge clk_i) begin
    if (rst_i) begin
      cmd_ready_o <= 1'b0;
    end else if (ce_i) begin
      cmd_ready_o <= fifo_in_ready && !fifo_full && !take_cmd &&
                     !wait_counter && !resp_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Response buffer and serial shifter

  response_fifo #(
    .WIDTH(`WORD_W),
    .DEPTH(`FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .in_valid_i(resp_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(resp_word),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(shifter_ready),
    .out_data_o(fifo_out_data),
    .full_o(fifo_full),
    .empty_o(fifo_empty)
  );

  response_shifter #(
    .WIDTH(`WORD_W)
  ) u_shifter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .word_valid_i(fifo_out_valid),
    .word_ready_o(shifter_ready),
    .word_i(fifo_out_data),
    .tx_en_o(own_tx_en),
    .tx_bit_o(own_tx_bit)
  );

  ////////////////////////////////////////////////////////////////////
  // Wishbone register slave

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl <= `CTRL_RESET;
      ident <= `IDENT_RESET;
    end else if (ce_i) begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0000_0000;
      if (wb_req && wb_we_i) begin
        case (wb_adr_i)
          `REG_CTRL: begin
            if (wb_sel_i[0]) begin
              ctrl[1:0] <= wb_dat_i[1:0];
            end
          end
          `REG_IDENT: begin
            if (wb_sel_i[0]) begin
              ident[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
              ident[15:8] <= wb_dat_i[15:8];
            end
          end
          default: begin
          end
        endcase
      end else if (wb_req) begin
        case (wb_adr_i)
          `REG_CTRL: wb_dat_o <= {30'd0, ctrl[1:0]};
          `REG_STATUS: begin
            wb_dat_o[`ST_HS_ACTIVE] <= hs_active;
            wb_dat_o[`ST_FIFO_FULL] <= fifo_full;
            wb_dat_o[`ST_FIFO_EMPTY] <= fifo_empty;
            wb_dat_o[`ST_HELD] <= held_valid;
            wb_dat_o[`ST_TX_BUSY] <= own_tx_en;
          end
          `REG_SAMPLE: wb_dat_o <= {16'h0000, held_sample};
          `REG_STROBES: wb_dat_o <= {16'h0000, strobe_count};
          `REG_IDENT: wb_dat_o <= {16'h0000, ident};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // satellite_cascade_handshake

// File: tb/downstream_node.sv
// Purpose: Downstream node on the chained transmit pair
// Assumes: One 16-bit word per send pulse, MSB first
// Notes: Data toggles while enable is low
module downstream_node (
  input clk_i,
  input rst_i,
  input send_i,
  input [15:0] word_i,
  output logic tx_en_o,
  output logic tx_dat_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [14:0] shreg;
  logic [3:0] left;
  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_en_o <= 1'b0;
      tx_dat_o <= 1'b0;
      left <= 4'h0;
    end else if (send_i && !tx_en_o) begin
      tx_en_o <= 1'b1;
      {tx_dat_o, shreg} <= word_i;
      left <= 4'hF;
    end else if (left != 4'h0) begin
      {tx_dat_o, shreg} <= {shreg, 1'b0};
      left <= left - 4'h1;
    end else begin
      tx_en_o <= 1'b0; // Idle enable low
      tx_dat_o <= !tx_dat_o;
    end
  end
endmodule // downstream_node

// File: tb/satellite_cascade_handshake_tb_top.sv
// Purpose: Self-checking bench for the cascade block
// Assumes: Clock enable and byte selects held high
// Notes: Scenarios run one after another
`include "satellite_cascade_defs.vh"
module satellite_cascade_handshake_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, mode = 1'b1, srx = 1'b0, rxo, cko;
  logic cen, cdat, send = 1'b0, tx_on, tx_bit, cv = 1'b0, ok = 1'b0, crdy, hsn = 1'b1;
  logic stbo, creq;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000, rdat;
  logic [5:0] sta = 6'h05, nxt;
  logic [3:0] code = 4'h0, ccode;
  logic [15:0] pins = 16'h0000, ctrv = 16'hBEEF, word = 16'hA5C3;
  int mismatches = 0;
  int samples_checked = 0;
  satellite_cascade_handshake u_satellite_cascade_handshake (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .station_address_in_i(sta), .address_output_mode_i(mode),
    .next_station_address_out_o(nxt), .clock_chain_out_o(cko), .serial_receive_in_i(srx),
    .receive_chain_out_o(rxo), .chained_tx_enable_in_i(cen), .chained_tx_data_in_i(cdat),
    .transmit_enable_out_o(tx_on), .transmit_data_out_o(tx_bit), .cmd_valid_i(cv),
    .cmd_code_i(code), .cmd_rp_ok_i(ok), .cmd_ready_o(crdy), .handshake_select_n_i(hsn),
    .parallel_input_pins_i(pins), .input_sample_strobe_o(stbo), .counter_req_o(creq),
    .counter_code_o(ccode), .counter_value_i(ctrv));
  downstream_node u_downstream_node (.clk_i(clk_i), .rst_i(rst_i), .send_i(send),
    .word_i(word), .tx_en_o(cen), .tx_dat_o(cdat));
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  ////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      check("bus ack", 1'b0, 1'b1);
      close_out();
    end
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic send_cmd(input logic [3:0] c, input logic k, input int tail,
                          output logic s, output logic q);
    int n;
    n = 0;
    @(posedge clk_i);
    cv <= 1'b1;
    code <= c;
    ok <= k;
    do begin
      @(posedge clk_i);
      n++;
    end while (crdy !== 1'b1 && n < 60);
    if (crdy !== 1'b1) begin
      check("command ready", 1'b0, 1'b1);
      close_out();
    end
    cv <= 1'b0;
    @(posedge clk_i);
    s = stbo;
    q = creq;
    if (q === 1'b1) check("counter code", ccode, c);
    repeat (tail) @(posedge clk_i);
  endtask
  task automatic grab(output logic [15:0] w);
    int n;
    n = 0;
    w = 16'h0000;
    do begin
      @(posedge clk_i);
      n++;
    end while (tx_on !== 1'b1 && n < 40);
    if (tx_on !== 1'b1) begin
      check("response start", 1'b0, 1'b1);
      close_out();
    end
    for (int i = 0; i < 16; i++) begin
      if (i > 0) @(posedge clk_i);
      w = {w[14:0], tx_bit};
    end
  endtask
  ////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] r;
    wb(1'b0, `REG_CTRL, 32'h0000_0000, r);
    check("ctrl reset", r, `CTRL_RESET);
    wb(1'b1, `REG_CTRL, 32'h0000_0000, r);
    wb(1'b0, `REG_CTRL, 32'h0000_0000, r);
    check("ctrl write", r, 32'h0000_0000);
    wb(1'b1, `REG_CTRL, `CTRL_RESET, r);
    wb(1'b0, `REG_IDENT, 32'h0000_0000, r);
    check("ident reset", r, {16'h0000, `IDENT_RESET});
    wb(1'b1, `REG_IDENT, 32'h0000_C3A5, r);
    wb(1'b0, `REG_IDENT, 32'h0000_0000, r);
    check("ident write", r, 32'h0000_C3A5);
    wb(1'b1, 8'h3C, 32'hFFFF_FFFF, r);
    wb(1'b0, 8'h3C, 32'h0000_0000, r);
    check("unmapped read", r, 32'h0000_0000);
    $display("test regs done");
  endtask
  task automatic t_addr;
    logic [5:0] a [4] = '{6'h00, 6'h15, 6'h2A, 6'h3E}; // Top address never chains
    foreach (a[i]) begin
      sta <= a[i];
      mode <= 1'b1;
      repeat (2) @(posedge clk_i);
      check("next address", nxt, a[i] + 6'h01);
      mode <= 1'b0;
      repeat (2) @(posedge clk_i);
      check("chaining off", nxt, 6'h00);
    end
    mode <= 1'b1;
    $display("test addr done");
  endtask
  task automatic t_rx;
    logic [7:0] pat = 8'hB4;
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      srx <= pat[i % 8];
      if (i >= 2) check("receive chain", rxo, pat[(i - 2) % 8]);
    end
    $display("test rx done");
  endtask
  task automatic t_hs;
    logic s, q;
    logic [31:0] r;
    logic [15:0] w;
    hsn <= 1'b0;
    pins <= 16'hA001;
    send_cmd(4'h0, 1'b1, 0, s, q);
    check("acked strobe", s, 1'b1);
    grab(w);
    check("fresh word", w, 16'hA001);
    wb(1'b0, `REG_SAMPLE, 32'h0000_0000, r);
    check("fresh sample", r, 32'h0000_A001);
    pins <= 16'h5AA5;
    send_cmd(4'h8, 1'b0, 0, s, q); // Controller saw no answer
    check("blocked strobe", s, 1'b0);
    grab(w);
    check("resent word", w, 16'hA001);
    wb(1'b0, `REG_SAMPLE, 32'h0000_0000, r);
    check("held sample", r, 32'h0000_A001);
    send_cmd(4'h8, 1'b1, 0, s, q);
    grab(w);
    check("next word", w, 16'h5AA5);
    wb(1'b0, `REG_SAMPLE, 32'h0000_0000, r);
    check("next sample", r, 32'h0000_5AA5);
    hsn <= 1'b1;
    send_cmd(4'h0, 1'b0, 5, s, q);
    check("free strobe", s, 1'b1);
    wb(1'b0, `REG_STROBES, 32'h0000_0000, r);
    check("strobe count", r, 32'h0000_0003);
    hsn <= 1'b0;
    $display("test handshake done");
  endtask
  task automatic t_codes;
    logic s, q;
    for (int c = 0; c < 16; c++) begin
      send_cmd(c[3:0], 1'b1, 5, s, q);
      check("sample strobe", s, c == 0 || c == 8);
      check("counter request", q, c inside {[1:6], [9:14]});
    end
    $display("test codes done");
  endtask
  task automatic t_fill;
    logic s, q;
    logic [31:0] r;
    int n;
    int quiet;
    n = 0;
    quiet = 0;
    repeat (16) send_cmd(4'h1, 1'b1, 0, s, q);
    wb(1'b0, `REG_STATUS, 32'h0000_0000, r);
    check("fifo full", r[`ST_FIFO_FULL], 1'b1);
    do begin
      wb(1'b0, `REG_STATUS, 32'h0000_0000, r);
      n++;
      // One idle cycle between words is not the end of the drain
      quiet = (r[`ST_TX_BUSY] === 1'b0 && r[`ST_FIFO_EMPTY] === 1'b1) ? quiet + 1 : 0;
    end while (quiet < 2 && n < 80);
    check("fifo empty", r[`ST_FIFO_EMPTY], 1'b1);
    check("tx idle", r[`ST_TX_BUSY], 1'b0);
    $display("test fill done");
  endtask
  task automatic t_merge;
    @(posedge clk_i);
    send <= 1'b1;
    @(posedge clk_i);
    send <= 1'b0;
    @(posedge clk_i);
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk_i);
      check("merged enable", tx_on, 1'b1);
      check("merged data", tx_bit, word[i]);
    end
    @(posedge clk_i);
    check("enable released", tx_on, 1'b0);
    check("gated data", tx_bit, 1'b0);
    $display("test merge done");
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk_i);
    #2;
    check("clock out high", cko, 1'b1);
    #4;
    check("clock out low", cko, 1'b0);
    check("address in reset", nxt, 6'h06);
    repeat (7) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_addr();
    t_rx();
    t_hs();
    t_codes();
    t_fill();
    t_merge();
    close_out();
  end
endmodule // satellite_cascade_handshake_tb_top

// File: tb/sch_props.sv
// Purpose: Port assertions for the cascade block
// Assumes: Force-handshake-off control bit stays clear
// Notes: Attached by bind below
module sch_props (
  input clk_i,
  input rst_i,
  input ce_i,
  input [5:0] station_address_in_i,
  input address_output_mode_i,
  input [5:0] next_station_address_out_o,
  input clock_chain_out_o,
  input serial_receive_in_i,
  input receive_chain_out_o,
  input chained_tx_enable_in_i,
  input chained_tx_data_in_i,
  input transmit_enable_out_o,
  input transmit_data_out_o,
  input cmd_valid_i,
  input [3:0] cmd_code_i,
  input cmd_rp_ok_i,
  input cmd_ready_o,
  input handshake_select_n_i,
  input input_sample_strobe_o,
  input counter_req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  wire take = cmd_valid_i && cmd_ready_o && ce_i;
  wire basic = cmd_code_i == 4'h0 || cmd_code_i == 4'h8;
  wire ident = cmd_code_i == 4'h7 || cmd_code_i == 4'hF;
  ////////////////////////////////////////
  addr_inc_a: assert property (ce_i && address_output_mode_i
    |=> next_station_address_out_o == $past(station_address_in_i) + 6'h01)
    else $error("next address wrong");
  addr_off_a: assert property (ce_i && !address_output_mode_i
    |=> next_station_address_out_o == 6'h00) else $error("next address not off");
  chain_clk_a: assert property (@(negedge clk_i) disable iff (1'b0)
    clock_chain_out_o) else $error("clock chain not high");
  chain_clk_low_a: assert property (@(posedge clk_i) disable iff (1'b0)
    !clock_chain_out_o) else $error("clock chain not low");
  rx_pass_a: assert property (ce_i |=> receive_chain_out_o == $past(serial_receive_in_i))
    else $error("receive chain wrong");
  tx_merge_a: assert property (ce_i && chained_tx_enable_in_i
    |=> transmit_enable_out_o && (transmit_data_out_o || !$past(chained_tx_data_in_i)))
    else $error("chained transmit lost");
  code_gate_a: assert property (take && !basic |=> !$rose(input_sample_strobe_o))
    else $error("strobe on other code");
  hs_block_a: assert property (take && basic && !handshake_select_n_i && !cmd_rp_ok_i
    |=> !$rose(input_sample_strobe_o)) else $error("strobe not blocked");
  hs_strobe_a: assert property (take && basic && (handshake_select_n_i || cmd_rp_ok_i)
    |=> $rose(input_sample_strobe_o) ##1 input_sample_strobe_o [*4] ##1 !input_sample_strobe_o)
    else $error("strobe missing or wrong length");
  ctr_route_a: assert property (take && !basic && !ident
    |=> counter_req_o ##1 !counter_req_o) else $error("counter request wrong");
endmodule // sch_props

bind satellite_cascade_handshake sch_props u_sch_props (.*);
